// >>> rtl/rtc_link_pkg.sv
// Constants and types shared by the two-wire register access block of the clock
package rtc_link_pkg;

  // Address byte layout
  localparam logic [6:0] SLAVE_ADDR     = 7'h32;
  localparam int         ADDR_FIELD_MSB = 7;
  localparam int         ADDR_FIELD_LSB = 1;
  localparam int         RW_BIT_POS     = 0;

  // Pointer byte layout and codes
  localparam int         PTR_FIELD_MSB  = 7;
  localparam int         PTR_FIELD_LSB  = 4;
  localparam int         FMT_FIELD_MSB  = 3;
  localparam int         FMT_FIELD_LSB  = 0;
  localparam logic [3:0] PTR_DEFAULT    = 4'hF;
  localparam logic [3:0] FMT_WRITE      = 4'h0;
  localparam logic [3:0] FMT_READ_AFTER = 4'h4;
  localparam logic [7:0] LOCKED_BYTE    = 8'hFF;

  // Byte and bit counting
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [1:0] IDX_ADDR       = 2'h0;
  localparam logic [1:0] IDX_PTR        = 2'h1;
  localparam logic [1:0] IDX_DATA       = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TIMEOUT_MS      = 500;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int CARRY_APPLY_US  = 61;

  // Serial engine phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } link_state_type;

  // Conditions seen on the synchronised pins
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } pin_event_type;

  // Register write strobe towards the timekeeping registers
  typedef struct packed {
    logic       en;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_write_type;

endpackage

// >>> rtl/rtc_reg_mem.sv
// Sixteen-word register store with registered read data
`timescale 1ns/1ns
module rtc_reg_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [2**AW];

  // Refuse a store shape that has no address or no data bits
  if (AW < 1 || DW < 1) begin : g_bad_shape
    $error("rtc_reg_mem needs AW and DW of at least 1");
  end

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Read port is registered so the serial engine sees a stable byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule // rtc_reg_mem

// >>> rtl/rtc_link_slave.sv
// Two-wire slave engine giving the master access to the clock registers
`timescale 1ns/1ns
module rtc_link_slave
  import rtc_link_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  input  wire logic    osc_clk_i,
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  output logic         sda_o,
  output logic         sda_oe_o,
  input  wire logic    carry_tick_i,
  output logic         carry_apply_o,
  output logic         hold_o,
  output reg_write_type reg_wr_o
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  // Refuse a timeout the counter cannot express
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYC must be at least 2");
  end

  logic [1:0]     scl_sync_reg;
  logic [1:0]     sda_sync_reg;
  logic           scl_q_reg;
  logic           sda_q_reg;
  pin_event_type  ev;
  logic           access_reg;
  logic           locked_reg;
  logic [TW-1:0]  timer_reg;
  logic           timeout_hit;
  link_state_type state_reg;
  logic [3:0]     bit_cnt_reg;
  logic [1:0]     byte_idx_reg;
  logic [7:0]     shift_reg;
  logic           rd_mode_reg;
  logic           drive_reg;
  logic [3:0]     ptr_reg;
  logic           byte_done;
  logic           tx_done;
  logic           addr_hit;
  logic           store_byte;
  logic [7:0]     mem_rdata;
  logic [7:0]     tx_byte;
  logic [1:0]     hold_sync_reg;
  logic           pending_reg;

  // Pins come from the master's domain: two flops, then one more for edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_q_reg    <= scl_sync_reg[1];
      sda_q_reg    <= sda_sync_reg[1];
    end
  end

  // Bus conditions, judged on the second synchroniser stage against the edge flop behind it
  always_comb begin
    ev.start    = scl_sync_reg[1] && scl_q_reg && sda_q_reg && !sda_sync_reg[1];
    ev.stop     = scl_sync_reg[1] && scl_q_reg && !sda_q_reg && sda_sync_reg[1];
    ev.scl_rise = scl_sync_reg[1] && !scl_q_reg;
    ev.scl_fall = !scl_sync_reg[1] && scl_q_reg;
  end

  // Byte level decodes
  assign byte_done   = (state_reg == ST_RX) && ev.scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
  assign tx_done     = (state_reg == ST_TX) && ev.scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
  assign addr_hit    = shift_reg[ADDR_FIELD_MSB:ADDR_FIELD_LSB] == SLAVE_ADDR;
  assign store_byte  = byte_done && (byte_idx_reg == IDX_DATA) && !locked_reg;
  assign timeout_hit = access_reg && (timer_reg == TW'(TIMEOUT_CYC - 1));
  assign tx_byte     = locked_reg ? LOCKED_BYTE : mem_rdata;

  // Access window: a start opens it, a stop or the timeout closes it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      access_reg <= 1'b0;
    end else if (ev.stop || timeout_hit) begin
      access_reg <= 1'b0;
    end else if (ev.start) begin
      access_reg <= 1'b1;
    end
  end
  // Timeout counts from the first start only; repeated starts leave it alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_reg <= '0;
    end else if (!access_reg) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + TW'(1);
    end
  end
  // Forced release state survives until the master sends a stop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_reg <= 1'b0;
    end else if (ev.stop) begin
      locked_reg <= 1'b0;
    end else if (timeout_hit) begin
      locked_reg <= 1'b1;
    end
  end
  // Register pointer: loaded, advanced per byte, reset to Fh at every end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_reg <= PTR_DEFAULT;
    end else if (ev.stop || timeout_hit) begin
      ptr_reg <= PTR_DEFAULT;
    end else if (byte_done && (byte_idx_reg == IDX_PTR) && !locked_reg) begin
      ptr_reg <= shift_reg[PTR_FIELD_MSB:PTR_FIELD_LSB];
    end else if (store_byte || tx_done) begin
      ptr_reg <= ptr_reg + 4'h1;
    end
  end
  // Write strobe carries the byte outward, registered on the same edge as the register store takes it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_wr_o <= '0;
    end else begin
      reg_wr_o.en   <= store_byte;
      reg_wr_o.addr <= ptr_reg;
      reg_wr_o.data <= shift_reg;
    end
  end

  // Serial engine: shift in on SCL rise, change SDA only after SCL falls
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= '0;
      byte_idx_reg <= IDX_ADDR;
      shift_reg    <= '0;
      rd_mode_reg  <= 1'b0;
      drive_reg    <= 1'b0;
    end else if (ev.stop || timeout_hit) begin
      state_reg <= ST_IDLE;
      drive_reg <= 1'b0;
    end else if (ev.start) begin
      state_reg    <= ST_RX;
      bit_cnt_reg  <= '0;
      byte_idx_reg <= IDX_ADDR;
      rd_mode_reg  <= 1'b0;
      drive_reg    <= 1'b0;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (ev.scl_rise && (bit_cnt_reg != BITS_PER_BYTE)) begin
            shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= '0;
            if (byte_idx_reg != IDX_DATA) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
            if (byte_idx_reg == IDX_ADDR) begin
              if (addr_hit && (shift_reg[RW_BIT_POS] || !locked_reg)) begin
                state_reg   <= ST_RX_ACK;
                drive_reg   <= 1'b1;
                rd_mode_reg <= shift_reg[RW_BIT_POS];
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (byte_idx_reg == IDX_PTR) begin
              state_reg   <= ST_RX_ACK;
              drive_reg   <= 1'b1;
              // Any code other than 4h keeps the access in write direction
              rd_mode_reg <= shift_reg[FMT_FIELD_MSB:FMT_FIELD_LSB] == FMT_READ_AFTER;
            end else begin
              state_reg <= ST_RX_ACK;
              drive_reg <= 1'b1;
            end
          end
        end
        ST_RX_ACK: begin
          if (ev.scl_fall && rd_mode_reg) begin
            state_reg   <= ST_TX;
            shift_reg   <= {tx_byte[6:0], 1'b0};
            drive_reg   <= !tx_byte[7];
            bit_cnt_reg <= 4'h1;
          end else if (ev.scl_fall) begin
            state_reg <= ST_RX;
            drive_reg <= 1'b0;
          end
        end
        ST_TX: begin
          if (tx_done) begin
            state_reg   <= ST_TX_ACK;
            drive_reg   <= 1'b0;
            bit_cnt_reg <= '0;
          end else if (ev.scl_fall) begin
            drive_reg   <= !shift_reg[7];
            shift_reg   <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        ST_TX_ACK: begin
          if (ev.scl_rise && sda_sync_reg[1]) begin
            state_reg <= ST_IDLE;
          end else if (ev.scl_fall) begin
            state_reg   <= ST_TX;
            shift_reg   <= {tx_byte[6:0], 1'b0};
            drive_reg   <= !tx_byte[7];
            bit_cnt_reg <= 4'h1;
          end
        end
        default: begin
          // Idle: ignore traffic until the next start
          drive_reg <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_reg;
  assign hold_o   = access_reg;

  rtc_reg_mem #(
    .AW (4),
    .DW (8)
  ) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (store_byte),
    .waddr_i (ptr_reg),
    .wdata_i (shift_reg),
    .raddr_i (ptr_reg),
    .rdata_o (mem_rdata)
  );

  // Hold level crosses to the oscillator domain by two flops
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_sync_reg <= 2'b00;
    end else begin
      hold_sync_reg <= {hold_sync_reg[0], access_reg};
    end
  end
  // A carry during the hold is remembered; set wins since clear needs no hold
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_reg <= 1'b0;
    end else if (carry_tick_i && hold_sync_reg[1]) begin
      pending_reg <= 1'b1;
    end else if (!hold_sync_reg[1]) begin
      pending_reg <= 1'b0;
    end
  end
  // Apply a carry at once when free, or the first cycle after the hold drops
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_apply_o <= 1'b0;
    end else begin
      carry_apply_o <= !hold_sync_reg[1] && (carry_tick_i || pending_reg);
    end
  end

  // Checks on the serial engine and the carry hold
  sequence s_timeout_fire;
    access_reg && (timer_reg == TW'(TIMEOUT_CYC - 1));
  endsequence
  sequence s_released;
    !access_reg && locked_reg && (ptr_reg == PTR_DEFAULT);
  endsequence
  property p_start_opens;
    @(posedge clk_i) disable iff (!rst_n_i)
      ev.start && !timeout_hit |=> (state_reg == ST_RX) && (bit_cnt_reg == 4'h0) && access_reg;
  endproperty
  a_start_opens: assert property (p_start_opens) else $error("start not taken");
  property p_stop_closes;
    @(posedge clk_i) disable iff (!rst_n_i)
      ev.stop |=> !access_reg && (ptr_reg == PTR_DEFAULT) && (state_reg == ST_IDLE);
  endproperty
  a_stop_closes: assert property (p_stop_closes) else $error("stop did not close");
  property p_ack_slot;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_RX_ACK) && !ev.scl_fall && !ev.stop && !timeout_hit && !ev.start
        |-> drive_reg;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack not driven");
  property p_foreign_addr;
    @(posedge clk_i) disable iff (!rst_n_i)
      byte_done && (byte_idx_reg == IDX_ADDR) && !addr_hit && !timeout_hit
        |=> (state_reg == ST_IDLE) && !drive_reg ##1 !drive_reg;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked");
  property p_ptr_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ptr_reg == PTR_DEFAULT) && (tx_done || store_byte) && !timeout_hit |=> ptr_reg == 4'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");
  property p_timeout;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_timeout_fire and !ev.stop |=> s_released;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout release wrong");
  property p_rstart_timer;
    @(posedge clk_i) disable iff (!rst_n_i)
      access_reg && ev.start && !timeout_hit |=> timer_reg == $past(timer_reg) + TW'(1);
  endproperty
  a_rstart_timer: assert property (p_rstart_timer) else $error("timer restarted");
  property p_locked_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      locked_reg && byte_done && (byte_idx_reg == IDX_ADDR) && !shift_reg[RW_BIT_POS]
        |=> !drive_reg;
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write acked");
  property p_store;
    @(posedge clk_i) disable iff (!rst_n_i)
      store_byte |=> reg_wr_o.en && (reg_wr_o.data == $past(shift_reg))
        && (reg_wr_o.addr == $past(ptr_reg));
  endproperty
  a_store: assert property (p_store) else $error("write strobe wrong");
  property p_fmt_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      byte_done && (byte_idx_reg == IDX_PTR) && (shift_reg[3:0] == FMT_READ_AFTER)
        && !timeout_hit |=> rd_mode_reg ##0 (state_reg == ST_RX_ACK);
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format 4h not read");
  property p_carry_held;
    @(posedge osc_clk_i) disable iff (!rst_n_i)
      hold_sync_reg[1] |=> !carry_apply_o;
  endproperty
  a_carry_held: assert property (p_carry_held) else $error("carry applied in hold");

endmodule // rtc_link_slave

// >>> rtl/rtc_link_unused.sv
// Intentionally empty
`timescale 1ns/1ns

// >>> bench/link_master_model.sv
// Two-wire bus master model that drives the clock's serial link
`timescale 1ns/1ns
module link_master_model #(
  parameter int HALF_CYC = 10,
  parameter int GAP_CYC  = 7750
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Both lines released while the bus is idle
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One third of a serial clock bit (its high phase), counted in system clocks
  task automatic half_period();
    repeat (HALF_CYC) @(posedge clk_i);
  endtask

  // Only this model makes start conditions; also used as repeated start
  task automatic start();
    half_period();
    sda_o <= 1'b1;
    half_period();
    scl_o <= 1'b1;
    half_period();
    sda_o <= 1'b0;
    half_period();
    scl_o <= 1'b0;
  endtask

  // Stop, then keep the bus quiet for the settle gap before any start
  task automatic stop();
    half_period();
    sda_o <= 1'b0;
    half_period();
    scl_o <= 1'b1;
    half_period();
    sda_o <= 1'b1;
    repeat (GAP_CYC) @(posedge clk_i);
  endtask

  // Data changes only mid low phase, so it never looks like a condition
  task automatic bit_io(input logic b, output logic r);
    half_period();
    sda_o <= b;
    half_period();
    scl_o <= 1'b1;
    half_period();
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  // Eight bits MSB first, then release for the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read is left unacknowledged by the caller
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule // link_master_model

// >>> bench/tb.sv
// Self-checking bench for the two-wire register access engine
`timescale 1ns/1ns
module tb
  import rtc_link_pkg::*;
;
  logic          clk;
  logic          osc;
  logic          rst_n;
  logic          carry_tick;
  logic          scl;
  logic          m_sda;
  logic          d_sda;
  logic          d_oe;
  logic          apply;
  logic          hold;
  reg_write_type wr;
  wire           sda = m_sda & ~(d_oe & ~d_sda);
  int            fail_count;
  int            checks;
  int            apply_count;
  logic [7:0]    d [3];
  logic [7:0]    b;
  logic          ack;
  reg_write_type wq [$];

  // Short timeout keeps the run brief; expectations use this value
  rtc_link_slave #(.TIMEOUT_CYC(2000)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .osc_clk_i(osc), .scl_i(scl), .sda_i(sda),
    .sda_o(d_sda), .sda_oe_o(d_oe), .carry_tick_i(carry_tick),
    .carry_apply_o(apply), .hold_o(hold), .reg_wr_o(wr)
  );

  link_master_model m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

  // System clock and unrelated oscillator clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #3 forever #80 osc = ~osc;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One carry pulse in the oscillator domain
  task automatic tick();
    @(posedge osc) carry_tick <= 1'b1;
    @(posedge osc) carry_tick <= 1'b0;
  endtask

  // Oldest expected store is taken whenever the engine writes a register
  always @(posedge clk) begin
    if (wr.en === 1'b1) begin
      if (wq.size() == 0) check("unexpected write", 16'(wr), 16'h0);
      else check("register write", 16'(wr), 16'(wq.pop_front()));
    end
  end

  // Counts applied carries as the registers would see them
  always @(posedge osc) begin
    if (apply === 1'b1) apply_count++;
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    carry_tick = 1'b0;
    fail_count = 0;
    checks = 0;
    apply_count = 0;
    b = 8'($urandom(59));
    for (int i = 0; i < 3; i++) d[i] = 8'($urandom());
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);

    // Write three bytes from Eh, crossing the wrap, with a carry held meanwhile
    m.start();
    m.send_byte(8'h64, ack);
    check("write address ack", ack, 1);
    m.send_byte(8'hE0, ack);
    check("pointer byte ack", ack, 1);
    check("hold during access", hold, 1);
    tick();
    for (int i = 0; i < 3; i++) begin
      wq.push_back(reg_write_type'{1'b1, 4'(4'hE + i), d[i]});
      m.send_byte(d[i], ack);
      check("data ack", ack, 1);
    end
    repeat (20) @(posedge osc);
    check("carry held", 16'(apply_count), 0);
    m.stop();
    check("hold after stop", hold, 0);
    check("carry applied after stop", 16'(apply_count), 1);
    check("writes pending", 16'(wq.size()), 16'h0);
    tick();
    repeat (4) @(posedge osc);
    check("carry while idle", 16'(apply_count), 2);
    $display("test write and carry done");

    // Read straight after start begins at Fh, wraps to 0h
    m.start();
    m.send_byte(8'h65, ack);
    check("read address ack", ack, 1);
    m.recv_byte(1'b1, b);
    check("read Fh", b, d[1]);
    m.recv_byte(1'b0, b);
    check("read 0h", b, d[2]);
    m.stop();
    $display("test default pointer read done");

    // Pointer set, then repeated start to read
    m.start();
    m.send_byte(8'h64, ack);
    m.send_byte(8'hE0, ack);
    m.start();
    m.send_byte(8'h65, ack);
    check("repeated start ack", ack, 1);
    m.recv_byte(1'b1, b);
    check("read Eh", b, d[0]);
    m.recv_byte(1'b0, b);
    check("read Fh next", b, d[1]);
    m.stop();
    $display("test repeated start read done");

    // Format 4h: data follows the pointer byte at once
    m.start();
    m.send_byte(8'h64, ack);
    m.send_byte(8'h04, ack);
    check("format 4h ack", ack, 1);
    m.recv_byte(1'b0, b);
    check("read after pointer", b, d[2]);
    m.stop();
    $display("test immediate read done");

    // Another slave's address is ignored
    m.start();
    m.send_byte(8'h66, ack);
    check("foreign address", ack, 0);
    m.stop();
    $display("test foreign address done");

    // Timeout counted from the first start, a repeated start in between
    m.start();
    m.send_byte(8'h64, ack);
    repeat (1200) @(posedge clk);
    m.start();
    m.send_byte(8'h64, ack);
    repeat (1000) @(posedge clk);
    check("hold after timeout", hold, 0);
    m.start();
    m.send_byte(8'h64, ack);
    check("locked write", ack, 0);
    m.start();
    m.send_byte(8'h65, ack);
    m.recv_byte(1'b0, b);
    check("locked read", b, 16'(LOCKED_BYTE));
    m.stop();
    m.start();
    m.send_byte(8'h64, ack);
    check("resumed write", ack, 1);
    m.stop();
    $display("test timeout done");
    end_of_test();
  end
endmodule // tb
